// *** pkg/swdt_defs.vh ***
// Constants for the sleep aware watchdog timer
// Function
// - Enabled watchdog requests a system reset when the counter reaches the period.
// - Counter advances only on low frequency oscillator ticks, 1 ms base interval.
// - Mode 11: watchdog active always, also during Sleep.
// - Mode 10: watchdog active while awake, disabled during Sleep.
// - Mode 01: software enable bit turns watchdog on or off, Sleep irrelevant.
// - Mode 00 disables; software enable ignored for modes 00 and 1x.
// - Five bit period select; any reset returns it to the two second code.
// - Code 00000 prescales by 32; each step doubles, up to 2^23 at 10010.
// - Codes 10011 to 11111 act as the minimum prescale of 32.
// - Counter clears on reset, clear, Sleep entry or exit, oscillator fail, disable.
// - Internal oscillator divider changes leave the counter untouched.
// - Cleared on Sleep entry, counts in Sleep if enabled, cleared on exit.
// - Timeout during Sleep wakes the device instead of resetting it.
// - Timeout updates timeout and powerdown flags, and outside Sleep also the watchdog reset flag.
// - Control register: period select bits 5:1, enable bit 0, bits 7:6 zero.
// - Sleep entry clears the powerdown flag and sets the timeout flag.
`ifndef SWDT_DEFS_VH
`define SWDT_DEFS_VH

// Register byte offsets
`define SWDT_ADR_CTRL 4'h0
`define SWDT_ADR_PWR 4'h1
`define SWDT_ADR_STAT 4'h2
`define SWDT_ADR_IRQS 4'h3
`define SWDT_ADR_IRQC 4'h4
`define SWDT_ADR_IRQE 4'h5

// Field positions
`define SWDT_CTRL_EN 0
`define SWDT_CTRL_PS_LO 1
`define SWDT_CTRL_PS_HI 5
`define SWDT_STAT_PDN 3
`define SWDT_STAT_TMO 4
`define SWDT_PWR_WRST 4

// Reset values
`define SWDT_PS_RST 5'h0B
`define SWDT_EN_RST 1'b0

// Period decode
`define SWDT_PS_MAX 5'h12
`define SWDT_BASE_SHIFT 5'h05
`define SWDT_MIN_TERM 23'h00001F

// Mode codes
`define SWDT_MODE_OFF 2'h0
`define SWDT_MODE_SW 2'h1
`define SWDT_MODE_AWAKE 2'h2
`define SWDT_MODE_ON 2'h3

// Interrupt bits
`define SWDT_IRQ_TMO 0
`define SWDT_IRQ_WAKE 1
`define SWDT_IRQ_OSCF 2

`endif

// *** test/swdt_sva.sv ***
// Port checker for the watchdog top module
`timescale 1ns/10ps
`default_nettype none
module swdt_sva (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Inputs
   input wire [1:0] watchdog_mode_cfg_i,
   input wire sys_reset_i,
   input wire watchdog_clear_instr_i,
   input wire in_sleep_i,
   // Outputs
   input wire wdt_reset_o,
   input wire wakeup_o,
   input wire timeout_flag_n_o,
   input wire powerdown_flag_n_o,
   input wire watchdog_reset_flag_n_o
);
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   rst_pulse_a: assert property (wdt_reset_o |=> !wdt_reset_o)
      else $error("reset pulse too long");
   wake_pulse_a: assert property (wakeup_o |=> !wakeup_o)
      else $error("wake pulse too long");
   sleep_norst_a: assert property (wdt_reset_o |-> !$past(in_sleep_i))
      else $error("reset in sleep");
   wake_sleep_a: assert property (wakeup_o |-> $past(in_sleep_i))
      else $error("wake while awake");
   off_quiet_a: assert property ($past(watchdog_mode_cfg_i) == 2'h0 |-> !wdt_reset_o && !wakeup_o)
      else $error("event when off");
   rst_flags_a: assert property (wdt_reset_o |-> ##[0:1] (!timeout_flag_n_o && !watchdog_reset_flag_n_o))
      else $error("reset flags");
   wake_flags_a: assert property (wakeup_o |-> ##[0:1] (!timeout_flag_n_o && !powerdown_flag_n_o))
      else $error("wake flags");
   sleep_pd_a: assert property ($rose(in_sleep_i) |-> ##[0:1] (!powerdown_flag_n_o && timeout_flag_n_o))
      else $error("sleep entry flags");
   clr_quiet_a: assert property (watchdog_clear_instr_i || sys_reset_i |-> ##2 !wdt_reset_o [*8])
      else $error("reset soon after clear");
endmodule // swdt_sva
bind swdt_top swdt_sva i_sva (.clk_i(clk_i), .rst_i(rst_i), .watchdog_mode_cfg_i(watchdog_mode_cfg_i),
   .sys_reset_i(sys_reset_i), .watchdog_clear_instr_i(watchdog_clear_instr_i), .in_sleep_i(in_sleep_i),
   .wdt_reset_o(wdt_reset_o), .wakeup_o(wakeup_o), .timeout_flag_n_o(timeout_flag_n_o),
   .powerdown_flag_n_o(powerdown_flag_n_o), .watchdog_reset_flag_n_o(watchdog_reset_flag_n_o));
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the watchdog timer
`timescale 1ns/10ps
`default_nettype none
`include "swdt_defs.vh"
module tb_top;
   reg clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, osc = 1'b0, ofail = 1'b0;
   reg clr = 1'b0, slp = 1'b0, srst = 1'b0, run = 1'b0, sel = 1'b1;
   reg [1:0] mode = 2'h3;
   reg [2:0] div = 3'h0;
   reg [3:0] adr = 4'h0;
   reg [4:0] c;
   reg [7:0] dat = 8'h00, rd;
   reg [19:0] codes = {5'h00, 5'h01, 5'h02, 5'h13};
   wire [7:0] dq;
   wire ack, wrst, wake, irq, tmo_n, pdn_n, rw_n;
   integer fails = 0, num_checks = 0, nr = 0, nw = 0, i, n, br, bw;
   swdt_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dq), .wb_ack_o(ack),
      .watchdog_mode_cfg_i(mode), .sys_reset_i(srst), .watchdog_clear_instr_i(clr), .in_sleep_i(slp),
      .low_freq_osc_i(osc), .osc_fail_i(ofail), .wdt_reset_o(wrst), .wakeup_o(wake), .irq_o(irq),
      .timeout_flag_n_o(tmo_n), .powerdown_flag_n_o(pdn_n), .watchdog_reset_flag_n_o(rw_n));
   initial forever #5 clk_i = ~clk_i;
   // Oscillator of 8 clocks a period, parked low; event counters
   always @(posedge clk_i) begin
      if (run && div[1:0] == 2'h3)
         osc <= ~osc;
      if (run)
         div <= div + 3'h1;
      if (wrst)
         nr <= nr + 1;
      if (wake)
         nw <= nw + 1;
   end
   task check(input [7:0] s, input [7:0] e);
      begin
         num_checks = num_checks + 1;
         if (s !== e) begin
            fails = fails + 1;
            $display("mismatch %0t %h %h", $time, s, e);
         end
      end
   endtask
   task finish_test;
      begin
         if (fails == 0 && num_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task bus(input w, input [3:0] a, input [7:0] d);
      begin
         cyc <= 1'b1;
         we <= w;
         adr <= a;
         dat <= d;
         @(posedge clk_i);
         while (ack !== 1'b1)
            @(posedge clk_i);
         rd = dq;
         cyc <= 1'b0;
         @(posedge clk_i);
      end
   endtask
   // Optional clear, k ticks, then count the events
   task go(input cl, input integer k, input [7:0] er, input [7:0] ew);
      begin
         clr <= cl;
         @(posedge clk_i);
         clr <= 1'b0;
         br = nr;
         bw = nw;
         run <= 1'b1;
         repeat (8 * k) @(posedge clk_i);
         run <= 1'b0;
         repeat (8) @(posedge clk_i);
         check(nr[7:0] - br[7:0], er);
         check(nw[7:0] - bw[7:0], ew);
      end
   endtask
   initial begin
      #500000;
      fails = fails + 1;
      finish_test;
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, `SWDT_ADR_CTRL, 8'h00);
      check(rd, 8'h16);
      bus(0, 4'hF, 8'h00);
      check(rd, 8'h00);
      bus(1, `SWDT_ADR_CTRL, 8'hFF);
      bus(0, `SWDT_ADR_CTRL, 8'h00);
      check(rd, 8'h3F);
      sel <= 1'b0;
      bus(1, `SWDT_ADR_CTRL, 8'h00);
      sel <= 1'b1;
      bus(0, `SWDT_ADR_CTRL, 8'h00);
      check(rd, 8'h3F);
      srst <= 1'b1;
      bus(0, `SWDT_ADR_CTRL, 8'h00);
      srst <= 1'b0;
      bus(0, `SWDT_ADR_CTRL, 8'h00);
      check(rd, 8'h16);
      for (i = 0; i < 4; i = i + 1) begin
         c = codes[i * 5 +: 5];
         n = (c > 5'h12) ? 32 : (32 << c);
         bus(1, `SWDT_ADR_CTRL, {2'b00, c, 1'b0});
         go(1, n - 1, 8'h00, 8'h00);
         go(1, n, 8'h01, 8'h00);
      end
      check({6'h00, tmo_n, rw_n}, 8'h00);
      bus(0, `SWDT_ADR_PWR, 8'h00);
      check(rd, 8'h00);
      bus(0, `SWDT_ADR_STAT, 8'h00);
      check(rd, 8'h08);
      bus(1, `SWDT_ADR_PWR, 8'h10);
      check({7'h00, rw_n}, 8'h01);
      bus(0, `SWDT_ADR_PWR, 8'h00);
      check(rd, 8'h10);
      bus(1, `SWDT_ADR_CTRL, 8'h00);
      go(1, 20, 8'h00, 8'h00);
      go(1, 31, 8'h00, 8'h00);
      ofail <= 1'b1;
      go(0, 31, 8'h00, 8'h00);
      ofail <= 1'b0;
      mode <= 2'h0;
      go(0, 40, 8'h00, 8'h00);
      mode <= 2'h3;
      go(0, 31, 8'h00, 8'h00);
      mode <= 2'h1;
      go(1, 40, 8'h00, 8'h00);
      bus(1, `SWDT_ADR_CTRL, 8'h01);
      go(1, 32, 8'h01, 8'h00);
      mode <= 2'h2;
      slp <= 1'b1;
      go(0, 40, 8'h00, 8'h00);
      slp <= 1'b0;
      go(1, 32, 8'h01, 8'h00);
      bus(1, `SWDT_ADR_IRQE, 8'h01);
      @(posedge clk_i);
      check({7'h00, irq}, 8'h01);
      bus(1, `SWDT_ADR_IRQE, 8'h02);
      @(posedge clk_i);
      check({7'h00, irq}, 8'h00);
      bus(0, `SWDT_ADR_IRQS, 8'h00);
      check(rd, 8'h05);
      bus(0, `SWDT_ADR_IRQE, 8'h00);
      check(rd, 8'h02);
      bus(1, `SWDT_ADR_IRQC, 8'h07);
      bus(0, `SWDT_ADR_IRQS, 8'h00);
      check(rd, 8'h00);
      mode <= 2'h3;
      go(1, 20, 8'h00, 8'h00);
      slp <= 1'b1;
      go(0, 31, 8'h00, 8'h00);
      check({6'h00, tmo_n, pdn_n}, 8'h02);
      bus(0, `SWDT_ADR_STAT, 8'h00);
      check(rd, 8'h10);
      go(0, 1, 8'h00, 8'h01);
      check({5'h00, tmo_n, pdn_n, irq}, 8'h01);
      go(0, 20, 8'h00, 8'h00);
      slp <= 1'b0;
      go(0, 31, 8'h00, 8'h00);
      finish_test;
   end
endmodule // tb_top
`default_nettype wire

// *** verilog/swdt_sync.v ***
// Two stage synchroniser with rising edge pulses
`timescale 1ns/10ps
`default_nettype none
module swdt_sync #(
   parameter W = 2
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Asynchronous levels
   input wire [W-1:0] async_i,
   // Synchronised levels and edges
   output reg [W-1:0] level_o,
   output reg [W-1:0] rise_o
);

reg [W-1:0] meta;
reg [W-1:0] prev;

genvar g;
generate
   for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge clk_i) begin
         if (rst_i) begin
            meta[g] <= 1'b0;
            level_o[g] <= 1'b0;
            prev[g] <= 1'b0;
            rise_o[g] <= 1'b0;
         end else begin
            meta[g] <= async_i[g];
            level_o[g] <= meta[g];
            prev[g] <= level_o[g];
            rise_o[g] <= level_o[g] & ~prev[g];
         end
      end
   end
endgenerate

endmodule // swdt_sync
`default_nettype wire

// *** verilog/swdt_top.v ***
// Sleep aware watchdog timer with Wishbone registers
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "swdt_defs.vh"
module swdt_top (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [3:0] wb_adr_i,
   input wire [7:0] wb_dat_i,
   input wire wb_sel_i,
   output reg [7:0] wb_dat_o,
   output reg wb_ack_o,
   // Configuration word
   input wire [1:0] watchdog_mode_cfg_i,
   // Core events
   input wire sys_reset_i,
   input wire watchdog_clear_instr_i,
   input wire in_sleep_i,
   // Pins from the oscillator section
   input wire low_freq_osc_i,
   input wire osc_fail_i,
   // Results
   output reg wdt_reset_o,
   output reg wakeup_o,
   output reg irq_o,
   output reg timeout_flag_n_o,
   output reg powerdown_flag_n_o,
   output reg watchdog_reset_flag_n_o
);

// Oscillator tick and fail edge
wire [1:0] sync_rise;
wire osc_tick;
wire osc_fail;

swdt_sync #(
   .W(2)
) u_sync (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .async_i({osc_fail_i, low_freq_osc_i}),
   .level_o(),
   .rise_o(sync_rise)
);

assign osc_tick = sync_rise[0];
assign osc_fail = sync_rise[1];

// Terminal count for a period code
function [22:0] swdt_term;
   input [4:0] ps;
   begin
      if (ps > `SWDT_PS_MAX) begin
         swdt_term = `SWDT_MIN_TERM;
      end else begin
         swdt_term = (23'h000001 << (ps + `SWDT_BASE_SHIFT)) - 23'h000001;
      end
   end
endfunction

// Whether the watchdog runs in a given mode
function swdt_active;
   input [1:0] mode;
   input sleep;
   input sw_en;
   begin
      case (mode)
         `SWDT_MODE_ON: swdt_active = 1'b1;
         `SWDT_MODE_AWAKE: swdt_active = ~sleep;
         `SWDT_MODE_SW: swdt_active = sw_en;
         default: swdt_active = 1'b0;
      endcase
   end
endfunction

// Registers
reg [4:0] period_sel;
reg sw_on;
reg [2:0] irq_stat;
reg [2:0] irq_en;
reg [22:0] count;
reg sleep_q;

wire active;
wire sleep_edge;
wire clr_cnt;
wire timeout;
wire wb_req;
wire wb_wr;
wire [2:0] irq_set;
wire [2:0] irq_clr;
wire [22:0] term;

assign active = swdt_active(watchdog_mode_cfg_i, in_sleep_i, sw_on);
assign sleep_edge = in_sleep_i ^ sleep_q;
assign term = swdt_term(period_sel);

// Wishbone handshake
assign wb_req = wb_cyc_i & wb_stb_i;
assign wb_wr = wb_req & wb_ack_o & wb_we_i & wb_sel_i;

always @(posedge clk_i) begin
   if (rst_i) begin
      wb_ack_o <= 1'b0;
   end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
   end
end

// Read data
always @(posedge clk_i) begin
   if (rst_i) begin
      wb_dat_o <= 8'h00;
   end else if (wb_req & ~wb_ack_o) begin
      case (wb_adr_i)
         `SWDT_ADR_CTRL: begin
            wb_dat_o <= {2'b00, period_sel, sw_on};
         end
         `SWDT_ADR_PWR: begin
            wb_dat_o <= {3'b000, watchdog_reset_flag_n_o, 4'h0};
         end
         `SWDT_ADR_STAT: begin
            wb_dat_o <= {3'b000, timeout_flag_n_o, powerdown_flag_n_o, 3'b000};
         end
         `SWDT_ADR_IRQS: begin
            wb_dat_o <= {5'h00, irq_stat};
         end
         `SWDT_ADR_IRQE: begin
            wb_dat_o <= {5'h00, irq_en};
         end
         default: begin
            wb_dat_o <= 8'h00;
         end
      endcase
   end
end

// Control register
always @(posedge clk_i) begin
   if (rst_i | sys_reset_i) begin
      period_sel <= `SWDT_PS_RST;
      sw_on <= `SWDT_EN_RST;
   end else if (wb_wr && wb_adr_i == `SWDT_ADR_CTRL) begin
      period_sel <= wb_dat_i[`SWDT_CTRL_PS_HI:`SWDT_CTRL_PS_LO];
      sw_on <= wb_dat_i[`SWDT_CTRL_EN];
   end
end

// Interrupt enable register
always @(posedge clk_i) begin
   if (rst_i) begin
      irq_en <= 3'h0;
   end else if (wb_wr && wb_adr_i == `SWDT_ADR_IRQE) begin
      irq_en <= wb_dat_i[2:0];
   end
end

// Sleep history
always @(posedge clk_i) begin
   if (rst_i) begin
      sleep_q <= 1'b0;
   end else begin
      sleep_q <= in_sleep_i;
   end
end

// Counter clear conditions; the divider select is not an input at all
assign clr_cnt = sys_reset_i | watchdog_clear_instr_i | sleep_edge | osc_fail | ~active;

// Prescaler and counter in one, fed only by oscillator ticks
assign timeout = active & ~clr_cnt & osc_tick & (count == term);

always @(posedge clk_i) begin
   if (rst_i) begin
      count <= 23'h000000;
   end else if (clr_cnt | timeout) begin
      count <= 23'h000000;
   end else if (osc_tick) begin
      count <= count + 23'h000001;
   end
end

// Reset request or wake pulse
always @(posedge clk_i) begin
   if (rst_i) begin
      wdt_reset_o <= 1'b0;
      wakeup_o <= 1'b0;
   end else begin
      wdt_reset_o <= timeout & ~in_sleep_i;
      wakeup_o <= timeout & in_sleep_i;
   end
end

// Status flags survive device resets
always @(posedge clk_i) begin
   if (rst_i) begin
      timeout_flag_n_o <= 1'b1;
      powerdown_flag_n_o <= 1'b1;
   end else if (timeout) begin
      timeout_flag_n_o <= 1'b0;
      powerdown_flag_n_o <= ~in_sleep_i;
   end else if (in_sleep_i & ~sleep_q) begin
      timeout_flag_n_o <= 1'b1;
      powerdown_flag_n_o <= 1'b0;
   end else if (watchdog_clear_instr_i) begin
      timeout_flag_n_o <= 1'b1;
      powerdown_flag_n_o <= 1'b1;
   end
end

// Watchdog reset flag, software rearms by writing one
always @(posedge clk_i) begin
   if (rst_i) begin
      watchdog_reset_flag_n_o <= 1'b1;
   end else if (timeout & ~in_sleep_i) begin
      watchdog_reset_flag_n_o <= 1'b0;
   end else if (wb_wr && wb_adr_i == `SWDT_ADR_PWR && wb_dat_i[`SWDT_PWR_WRST]) begin
      watchdog_reset_flag_n_o <= 1'b1;
   end
end

// Sticky interrupt status, set wins over clear
assign irq_set = {osc_fail, timeout & in_sleep_i, timeout};
assign irq_clr = (wb_wr && wb_adr_i == `SWDT_ADR_IRQC) ? wb_dat_i[2:0] : 3'h0;

always @(posedge clk_i) begin
   if (rst_i) begin
      irq_stat <= 3'h0;
   end else begin
      irq_stat <= irq_set | (irq_stat & ~irq_clr);
   end
end

always @(posedge clk_i) begin
   if (rst_i) begin
      irq_o <= 1'b0;
   end else begin
      irq_o <= |((irq_set | (irq_stat & ~irq_clr)) & irq_en);
   end
end

endmodule // swdt_top
`default_nettype wire
